// >>> verilog/ufs_pkg.sv
// package: register map, field positions and reset values of the uart fifo/status block
package ufs_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_DATA = 32'h5000_1000;
    localparam logic [31:0] ADDR_FCR = 32'h5000_1008;
    localparam logic [31:0] ADDR_MCR = 32'h5000_1010;
    localparam logic [31:0] ADDR_STATUS = 32'h5000_107C;
    localparam logic [31:0] ADDR_TX_FILL = 32'h5000_1080;
    localparam logic [31:0] ADDR_RX_FILL = 32'h5000_1084;
    localparam logic [31:0] ADDR_SRR = 32'h5000_1088;
    localparam logic [31:0] ADDR_SRTS = 32'h5000_108C;

    // fifo_status fields
    localparam int ST_RX_FULL = 4;
    localparam int ST_RX_NONEMPTY = 3;
    localparam int ST_TX_EMPTY = 2;
    localparam int ST_TX_ROOM = 1;

    // software_reset_control fields
    localparam int SRR_TX_CLEAR = 2;
    localparam int SRR_RX_CLEAR = 1;
    localparam int SRR_SOFT_RESET = 0;

    // modem_control_reg fields
    localparam int MCR_RTS = 1;
    localparam int MCR_LOOP = 4;
    localparam int MCR_AUTO_FLOW = 5;

    // fifo_control_reg fields
    localparam int FCR_ENABLE = 0;
    localparam int FCR_RX_CLEAR = 1;
    localparam int FCR_TX_CLEAR = 2;
    localparam int FCR_THR_LSB = 4;
    localparam int RX_THR_W = 2;

    // shadow_send_request field
    localparam int SRTS_BIT = 0;

    // widths and values after reset
    localparam int LEVEL_W = 16;
    localparam logic [LEVEL_W-1:0] RST_LEVEL = 16'h0000;
    localparam logic RST_TX_ROOM = 1'h1;
    localparam logic RST_RTS = 1'h0;
    localparam logic RST_RTS_N = 1'h1;
    localparam logic RST_FIFO_EN = 1'h0;
    localparam logic [RX_THR_W-1:0] RST_THR = 2'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // edges from the end of the soft reset pulse to controller reset release
    localparam int RST_RELEASE_CYC = 2;

    typedef enum {
        SEL_NONE,
        SEL_DATA,
        SEL_FCR,
        SEL_MCR,
        SEL_STATUS,
        SEL_TX_FILL,
        SEL_RX_FILL,
        SEL_SRR,
        SEL_SRTS
    } ufs_sel_t;

endpackage

// >>> verilog/ufs_fifo.sv
// shift-register fifo with registered outputs and fill level
`timescale 1ns/100ps
module ufs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // pointer reset, empties the fifo
    input wire logic clear_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    // occupancy
    output logic [ufs_pkg::LEVEL_W-1:0] level_o
);

    if (DEPTH < 2 || DEPTH >= (1 << ufs_pkg::LEVEL_W) || WIDTH < 1) begin : g_check
        $error("ufs_fifo: unsupported WIDTH or DEPTH");
    end

    localparam int LW = ufs_pkg::LEVEL_W;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [ufs_pkg::LEVEL_W-1:0] level;
        logic out_valid;
        logic in_ready;
    } ufs_fifo_t;

    ufs_fifo_t st_reg;
    ufs_fifo_t st_next;

    // head always sits in slot 0, so the output data is a flop
    always_comb begin
        logic [ufs_pkg::LEVEL_W-1:0] cnt;
        logic push;
        logic pop;
        cnt = st_reg.level;
        push = in_valid_i & st_reg.in_ready;
        pop = st_reg.out_valid & out_ready_i;
        st_next = st_reg;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_next.mem[i] = st_reg.mem[i+1];
            end
            cnt = cnt - 1'b1;
        end
        if (push) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (cnt == LW'(i)) begin
                    st_next.mem[i] = in_data_i;
                end
            end
            cnt = cnt + 1'b1;
        end
        // clear beats a push in the same cycle
        if (clear_i) begin
            cnt = ufs_pkg::RST_LEVEL;
        end
        st_next.level = cnt;
        st_next.out_valid = (cnt != ufs_pkg::RST_LEVEL);
        st_next.in_ready = (cnt < LW'(DEPTH));
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
            st_reg.in_ready <= ufs_pkg::RST_TX_ROOM;
            st_reg.level <= ufs_pkg::RST_LEVEL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready_o = st_reg.in_ready;
    assign out_valid_o = st_reg.out_valid;
    assign out_data_o = st_reg.mem[0];
    assign level_o = st_reg.level;

endmodule

// >>> verilog/ufs_top.sv
// uart fifo status, fifo level, soft reset and send-request control behind apb
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module ufs_top #(
    parameter int DATA_W = 8,
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic [31:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // transmit stream toward the shifter
    output logic tx_valid_o,
    output logic [DATA_W-1:0] tx_data_o,
    input wire logic tx_ready_i,
    // receive stream from the shifter
    input wire logic rx_valid_i,
    input wire logic [DATA_W-1:0] rx_data_i,
    output logic rx_ready_o,
    // modem side and controls for the rest of the uart
    output logic rts_n_o,
    output logic loop_rts_o,
    output logic loopback_o,
    output logic auto_flow_o,
    output logic fifo_enable_o,
    output logic uart_rst_n_o
);

    if (DATA_W < 1 || DATA_W > 32) begin : g_check
        $error("ufs_top: DATA_W must be 1 to 32");
    end

    localparam int LW = ufs_pkg::LEVEL_W;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic rx_taken;
        logic soft_req;
    } ufs_bus_t;

    typedef struct packed {
        logic rts;
        logic loop;
        logic auto_flow;
        logic fifo_en;
        logic [ufs_pkg::RX_THR_W-1:0] thr;
        logic rts_n;
        logic loop_rts;
    } ufs_core_t;

    ufs_bus_t bus_reg;
    ufs_bus_t bus_next;
    ufs_core_t core_reg;
    ufs_core_t core_next;
    logic sync1_reg;
    logic sync2_reg;
    logic arst_n;
    logic core_rst_n;

    logic tx_room;
    logic tx_clear;
    logic tx_push;
    logic [LW-1:0] tx_level;
    logic rx_nonempty;
    logic rx_clear;
    logic rx_pop;
    logic [DATA_W-1:0] rx_head;
    logic [LW-1:0] rx_level;

    ufs_pkg::ufs_sel_t sel;
    logic access;
    logic wr;
    logic rd;

    function automatic ufs_pkg::ufs_sel_t decode(input logic [31:0] addr);
        case (addr)
            ufs_pkg::ADDR_DATA: decode = ufs_pkg::SEL_DATA;
            ufs_pkg::ADDR_FCR: decode = ufs_pkg::SEL_FCR;
            ufs_pkg::ADDR_MCR: decode = ufs_pkg::SEL_MCR;
            ufs_pkg::ADDR_STATUS: decode = ufs_pkg::SEL_STATUS;
            ufs_pkg::ADDR_TX_FILL: decode = ufs_pkg::SEL_TX_FILL;
            ufs_pkg::ADDR_RX_FILL: decode = ufs_pkg::SEL_RX_FILL;
            ufs_pkg::ADDR_SRR: decode = ufs_pkg::SEL_SRR;
            ufs_pkg::ADDR_SRTS: decode = ufs_pkg::SEL_SRTS;
            default: decode = ufs_pkg::SEL_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode, one wait state so read data comes from a flop

    assign sel = decode(paddr_i);
    assign access = psel_i & penable_i;
    assign wr = access & bus_reg.pready & pwrite_i;
    assign rd = access & bus_reg.pready & ~pwrite_i;

    always_comb begin
        logic [31:0] rdata;
        rdata = ufs_pkg::READ_ZERO;
        bus_next = bus_reg;
        case (sel)
            ufs_pkg::SEL_DATA: rdata[DATA_W-1:0] = rx_nonempty ? rx_head : '0;
            ufs_pkg::SEL_FCR: begin
                rdata[ufs_pkg::FCR_ENABLE] = core_reg.fifo_en;
                rdata[ufs_pkg::FCR_THR_LSB +: ufs_pkg::RX_THR_W] = core_reg.thr;
            end
            ufs_pkg::SEL_MCR: begin
                rdata[ufs_pkg::MCR_RTS] = core_reg.rts;
                rdata[ufs_pkg::MCR_LOOP] = core_reg.loop;
                rdata[ufs_pkg::MCR_AUTO_FLOW] = core_reg.auto_flow;
            end
            ufs_pkg::SEL_STATUS: begin
                rdata[ufs_pkg::ST_RX_FULL] = (rx_level == LW'(FIFO_DEPTH));
                rdata[ufs_pkg::ST_RX_NONEMPTY] = rx_nonempty;
                rdata[ufs_pkg::ST_TX_EMPTY] = (tx_level == ufs_pkg::RST_LEVEL);
                rdata[ufs_pkg::ST_TX_ROOM] = tx_room;
            end
            ufs_pkg::SEL_TX_FILL: rdata[LW-1:0] = tx_level;
            ufs_pkg::SEL_RX_FILL: rdata[LW-1:0] = rx_level;
            ufs_pkg::SEL_SRTS: rdata[ufs_pkg::SRTS_BIT] = core_reg.rts;
            default: rdata = ufs_pkg::READ_ZERO; // write-only bits read as zero
        endcase
        bus_next.pready = access & ~bus_reg.pready;
        bus_next.prdata = ufs_pkg::READ_ZERO;
        bus_next.pslverr = 1'b0;
        bus_next.rx_taken = 1'b0;
        if (access && !bus_reg.pready) begin
            bus_next.prdata = pwrite_i ? ufs_pkg::READ_ZERO : rdata;
            bus_next.pslverr = (sel == ufs_pkg::SEL_NONE);
            // pop only what was actually captured, a late push must not be lost
            bus_next.rx_taken = ~pwrite_i & (sel == ufs_pkg::SEL_DATA) & rx_nonempty;
        end
        // self-clearing: high for one cycle after the write
        bus_next.soft_req = wr & (sel == ufs_pkg::SEL_SRR) & pwdata_i[ufs_pkg::SRR_SOFT_RESET];
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_reg <= '0;
        end else begin
            bus_reg <= bus_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // controller reset: asserts asynchronously, releases on the clock

    // single clock here, so this one reset covers every domain
    assign arst_n = resetn_i & ~bus_reg.soft_req;

    always_ff @(posedge ref_clk_i or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= 1'b1;
            sync2_reg <= sync1_reg;
        end
    end

    assign core_rst_n = sync2_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // control registers and send-request output

    always_comb begin
        logic wr_fcr;
        logic above;
        wr_fcr = wr & (sel == ufs_pkg::SEL_FCR);
        above = (rx_level > LW'(core_reg.thr));
        core_next = core_reg;
        if (wr && sel == ufs_pkg::SEL_MCR) begin
            core_next.rts = pwdata_i[ufs_pkg::MCR_RTS];
            core_next.loop = pwdata_i[ufs_pkg::MCR_LOOP];
            core_next.auto_flow = pwdata_i[ufs_pkg::MCR_AUTO_FLOW];
        end
        if (wr && sel == ufs_pkg::SEL_SRTS) begin
            core_next.rts = pwdata_i[ufs_pkg::SRTS_BIT];
        end
        if (wr_fcr) begin
            core_next.fifo_en = pwdata_i[ufs_pkg::FCR_ENABLE];
            core_next.thr = pwdata_i[ufs_pkg::FCR_THR_LSB +: ufs_pkg::RX_THR_W];
        end
        if (core_reg.loop) begin
            core_next.rts_n = 1'b1;
        end else if (core_reg.auto_flow && core_reg.fifo_en) begin
            core_next.rts_n = ~core_reg.rts | above;
        end else begin
            core_next.rts_n = ~core_reg.rts;
        end
        core_next.loop_rts = core_reg.loop & core_reg.rts;
    end

    always_ff @(posedge ref_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            core_reg <= '0;
            core_reg.rts <= ufs_pkg::RST_RTS;
            core_reg.fifo_en <= ufs_pkg::RST_FIFO_EN;
            core_reg.thr <= ufs_pkg::RST_THR;
            core_reg.rts_n <= ufs_pkg::RST_RTS_N;
        end else begin
            core_reg <= core_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fifos

    // disabling the fifos also empties them
    assign tx_clear = wr & (((sel == ufs_pkg::SEL_SRR) & pwdata_i[ufs_pkg::SRR_TX_CLEAR])
        | ((sel == ufs_pkg::SEL_FCR)
        & (pwdata_i[ufs_pkg::FCR_TX_CLEAR] | (core_reg.fifo_en & ~pwdata_i[ufs_pkg::FCR_ENABLE]))));
    assign rx_clear = wr & (((sel == ufs_pkg::SEL_SRR) & pwdata_i[ufs_pkg::SRR_RX_CLEAR])
        | ((sel == ufs_pkg::SEL_FCR)
        & (pwdata_i[ufs_pkg::FCR_RX_CLEAR] | (core_reg.fifo_en & ~pwdata_i[ufs_pkg::FCR_ENABLE]))));
    // a data write into a full fifo is dropped
    assign tx_push = wr & (sel == ufs_pkg::SEL_DATA);
    assign rx_pop = rd & bus_reg.rx_taken;

    ufs_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk_i(ref_clk_i),
        .resetn_i(core_rst_n),
        .clear_i(tx_clear),
        .in_valid_i(tx_push),
        .in_data_i(pwdata_i[DATA_W-1:0]),
        .in_ready_o(tx_room),
        .out_valid_o(tx_valid_o),
        .out_data_o(tx_data_o),
        .out_ready_i(tx_ready_i),
        .level_o(tx_level)
    );

    ufs_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk_i(ref_clk_i),
        .resetn_i(core_rst_n),
        .clear_i(rx_clear),
        .in_valid_i(rx_valid_i),
        .in_data_i(rx_data_i),
        .in_ready_o(rx_ready_o),
        .out_valid_o(rx_nonempty),
        .out_data_o(rx_head),
        .out_ready_i(rx_pop),
        .level_o(rx_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata_o = bus_reg.prdata;
    assign pready_o = bus_reg.pready;
    assign pslverr_o = bus_reg.pslverr;
    assign rts_n_o = core_reg.rts_n;
    assign loop_rts_o = core_reg.loop_rts;
    assign loopback_o = core_reg.loop;
    assign auto_flow_o = core_reg.auto_flow;
    assign fifo_enable_o = core_reg.fifo_en;
    assign uart_rst_n_o = sync2_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!core_rst_n);

    sequence s_soft_write;
        bus_reg.soft_req;
    endsequence

    sequence s_release;
        !sync2_reg ##[1:3] sync2_reg;
    endsequence

    a_tx_room_flag: assert property (tx_room == (tx_level < LW'(FIFO_DEPTH)))
        else $error("tx room flag disagrees with tx level");

    a_tx_level_count: assert property ((tx_push && tx_room && !tx_clear
        && !(tx_valid_o && tx_ready_i)) |=> tx_level == $past(tx_level) + 1'b1)
        else $error("tx level did not count a push");

    a_rx_level_count: assert property ((rx_pop && !rx_clear && !(rx_valid_i && rx_ready_o))
        |=> rx_level == $past(rx_level) - 1'b1)
        else $error("rx level did not count a pop");

    a_tx_clear_empty: assert property (tx_clear |=> tx_level == '0 && tx_room)
        else $error("tx clear did not empty the fifo");

    a_rx_clear_empty: assert property (rx_clear |=> rx_level == '0 && !rx_nonempty)
        else $error("rx clear did not empty the fifo");

    a_soft_reset_seq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_soft_write |-> s_release)
        else $error("soft reset did not assert then release");

    a_shadow_alias: assert property ((wr && sel == ufs_pkg::SEL_SRTS)
        |=> core_reg.rts == $past(pwdata_i[ufs_pkg::SRTS_BIT]))
        else $error("shadow write did not reach the rts control");

    a_rts_plain: assert property ((!core_reg.loop && !core_reg.auto_flow)
        |=> rts_n_o == !$past(core_reg.rts))
        else $error("send request output wrong with auto flow off");

    a_rts_gated: assert property ((!core_reg.loop && core_reg.auto_flow && core_reg.fifo_en
        && rx_level > LW'(core_reg.thr)) |=> rts_n_o)
        else $error("send request not released above threshold");

    a_loop_hold: assert property (core_reg.loop
        |=> rts_n_o && loop_rts_o == $past(core_reg.rts))
        else $error("loopback did not hold the output high");

    a_rx_full_flag: assert property ((bus_reg.pready && !pwrite_i && sel == ufs_pkg::SEL_STATUS
        && $past(rx_level) == LW'(FIFO_DEPTH)) |-> prdata_o[ufs_pkg::ST_RX_FULL])
        else $error("rx full flag missing from status");

    a_srr_reads_zero: assert property ((bus_reg.pready && sel == ufs_pkg::SEL_SRR)
        |-> prdata_o == ufs_pkg::READ_ZERO)
        else $error("reset control read was not zero");

endmodule

// >>> verif/ufs_modem_model.sv
// modem model: paces rx bytes by the send request, takes tx bytes slowly
`timescale 1ns/100ps
module ufs_modem_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // link side
    input wire logic rts_n_i,
    input wire logic rx_ready_i,
    input wire logic drain_en_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o
);
    logic [7:0] cnt;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_ready_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h5A;
            cnt <= 8'hA0;
        end else begin
            // slow taker: ready every other cycle at most
            tx_ready_o <= drain_en_i & ~tx_ready_o;
            if (rx_valid_o) begin
                if (rx_ready_i) begin
                    rx_valid_o <= 1'b0;
                    cnt <= cnt + 8'h01;
                end
            end else if (!rts_n_i) begin
                rx_valid_o <= 1'b1;
                rx_data_o <= cnt;
            end else begin
                // idle data keeps moving so a stale byte never looks valid
                rx_data_o <= ~rx_data_o;
            end
        end
    end
endmodule

// >>> verif/uart_fifo_status_reset_rts_tb.sv
// self-checking bench for the fifo status, soft reset and send request block
`timescale 1ns/100ps
module uart_fifo_status_reset_rts_tb;
    localparam logic [31:0] A_DAT = ufs_pkg::ADDR_DATA;
    localparam logic [31:0] A_MCR = ufs_pkg::ADDR_MCR;
    localparam logic [31:0] A_ST = ufs_pkg::ADDR_STATUS;
    localparam logic [31:0] A_TF = ufs_pkg::ADDR_TX_FILL;
    localparam logic [31:0] A_RF = ufs_pkg::ADDR_RX_FILL;
    localparam logic [31:0] A_SRR = ufs_pkg::ADDR_SRR;
    localparam logic [31:0] A_SRTS = ufs_pkg::ADDR_SRTS;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, drain = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, seed = 32'h61;
    logic pready_o, pslverr_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o;
    logic [7:0] tx_data_o, rx_data_i;
    logic rts_n_o, loop_rts_o, loopback_o, auto_flow_o, fifo_enable_o, uart_rst_n_o;
    logic [7:0] txq[$], rxq[$];
    int num_errors = 0, num_checks = 0, cyc = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    ufs_top ufs_top_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
        .rts_n_o(rts_n_o), .loop_rts_o(loop_rts_o), .loopback_o(loopback_o),
        .auto_flow_o(auto_flow_o), .fifo_enable_o(fifo_enable_o),
        .uart_rst_n_o(uart_rst_n_o));
    ufs_modem_model ufs_modem_model_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .rts_n_i(rts_n_o), .rx_ready_i(rx_ready_o), .drain_en_i(drain),
        .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc++;
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) chk(tx_data_o, txq.pop_front());
        if (rx_valid_i === 1'b1 && rx_ready_o === 1'b1) rxq.push_back(rx_data_i);
        if (cyc == 6000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] stat();
        return {27'h0, rxq.size() == 4, rxq.size() != 0, txq.size() == 0, txq.size() != 4, 1'b0};
    endfunction

    // master holds every field until the edge that samples pready high, takes the answer there
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        if (a == A_DAT && txq.size() < 4) txq.push_back(d[7:0]);
        if (a == A_SRR && d[2]) txq.delete();
        if (a == A_SRR && d[1]) rxq.delete();
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        if (a == A_DAT) x = {24'h0, rxq.pop_front()};
        chk(r, x);
        chk({31'h0, e}, {31'h0, a[11:8] == 4'hF});
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pause(2);
        resetn_i <= 1'b1;
        pause(3);
        rd(A_ST, 32'h0000_0006);
        rd(A_TF, 32'h0);
        rd(A_RF, 32'h0);
        rd(A_SRR, 32'h0);
        rd(A_SRTS, 32'h0);
        rd(32'h5000_1FF0, 32'h0);
        chk({31'h0, rts_n_o}, 32'h1);
        $display("reset values done");
        wr(ufs_pkg::ADDR_FCR, 32'h0000_0031);
        repeat (5) wr(A_DAT, rnd());
        rd(A_TF, 32'h4);
        rd(A_ST, stat());
        wr(A_SRR, 32'h0);
        rd(A_TF, 32'h4);
        wr(A_SRR, 32'h4);
        rd(A_TF, 32'h0);
        drain <= 1'b1;
        repeat (3) wr(A_DAT, rnd());
        pause(20);
        rd(A_TF, 32'h0);
        rd(A_ST, stat());
        $display("tx fifo done");
        wr(A_SRTS, 32'h1);
        rd(A_MCR, 32'h2);
        pause(2);
        chk({31'h0, rts_n_o}, 32'h0);
        pause(30);
        rd(A_RF, 32'h4);
        rd(A_ST, stat());
        wr(A_MCR, 32'h0);
        rd(A_SRTS, 32'h0);
        chk({31'h0, rts_n_o}, 32'h1);
        $display("send request done");
        wr(A_MCR, 32'h22);
        rd(A_DAT, 32'h0);
        pause(30);
        chk({31'h0, rts_n_o}, 32'h1);
        chk({31'h0, auto_flow_o}, 32'h1);
        rd(A_RF, rxq.size());
        wr(A_MCR, 32'h0);
        wr(A_SRR, 32'h0);
        rd(A_RF, rxq.size());
        wr(A_SRR, 32'h2);
        pause(10);
        rd(A_RF, rxq.size());
        while (rxq.size() != 0) rd(A_DAT, 32'h0);
        $display("auto flow done");
        wr(A_MCR, 32'h12);
        pause(3);
        chk({30'h0, rts_n_o, loop_rts_o}, 32'h3);
        rd(A_SRTS, 32'h1);
        $display("loopback done");
        wr(A_SRR, 32'h1);
        @(negedge ref_clk_i);
        chk({31'h0, uart_rst_n_o}, 32'h0);
        txq.delete();
        rxq.delete();
        while (uart_rst_n_o !== 1'b1) @(negedge ref_clk_i);
        pause(2);
        rd(A_SRTS, 32'h0);
        rd(A_TF, 32'h0);
        rd(A_ST, stat());
        chk({29'h0, rts_n_o, loopback_o, fifo_enable_o}, 32'h4);
        $display("soft reset done");
        tally_and_finish();
    end
endmodule
